// ---- rtl/user_feature_config.sv ----
`timescale 1ns/1ps
`include "user_feature_config_map.svh"
module user_feature_config
   import user_feature_config_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic                      irq,
   input  wire logic                 diode_emulation_mode,
   input  wire logic                 low_side_min_elapsed,
   input  wire logic                 power_good_status,
   input  user_feature_config_pkg::temp_fault_type temp_fault_in,
   input  wire logic                 monitor_above_limit,
   input  wire logic                 internal_clock,
   input  wire logic                 sync_in,
   input  wire logic                 fault_bus_in,
   input  wire logic                 fault_send_req,
   output logic                      min_duty_enable,
   output logic [`UFC_DUTY_NUM_WIDTH-1:0] min_duty_numerator,
   output logic                      force_low_side_pulse,
   output logic                      external_temp_sense_enable,
   output logic                      tracking_input,
   output logic                      monitor_input_enable,
   output logic                      power_good_output,
   output logic                      power_good_output_oe_n,
   output logic                      temp_fault,
   output logic                      latch_off,
   output logic                      use_external_clock,
   output logic                      switch_clock,
   output logic                      sync_out,
   output logic                      sync_oe_n,
   output logic                      fault_bus_out,
   output logic                      fault_bus_oe_n,
   output logic                      fault_bus_event
);

   ////////////////////////////////////////////////////////////////////////////
   // Storage and internal signals.

   ufc_type                    cfg_r;        // User feature configuration.
   logic [`UFC_IRQ_WIDTH-1:0]  irq_stat_r;   // Sticky event flags.
   logic [`UFC_IRQ_WIDTH-1:0]  irq_en_r;     // Interrupt enables.
   logic [`UFC_IRQ_WIDTH-1:0]  irq_set;      // Events raised this cycle.
   logic [`UFC_IRQ_WIDTH-1:0]  irq_clr;      // Bits cleared by software.
   logic [2:0]                 pin_meta_r;   // First synchroniser stage.
   logic [2:0]                 pin_sync_r;   // Second synchroniser stage.
   logic                       mon_high;     // Monitor pin above limit.
   logic                       ext_clk_in;   // External clock from sync pin.
   logic                       bus_msg_in;   // Fault bus message level.
   logic                       temp_fault_r; // Previous fault level.
   logic                       conflict;     // Temperature source not enabled.
   logic                       sel_fault;    // Fault of the chosen source.
   logic                       setup;        // Setup phase of a transfer.
   logic                       wr_access;    // Write taking effect.
   logic                       mapped;       // Address hits a register.
   logic [31:0]                rd_word;      // Read data before the flop.

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: pins outside the clock domain pass two flops.

   // Second stage alone feeds the logic; the first stage is not read.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_r <= 3'h0;
         pin_sync_r <= 3'h0;
      end else begin
         pin_meta_r <= {fault_bus_in, sync_in, monitor_above_limit};
         pin_sync_r <= pin_meta_r;
      end
   end

   assign mon_high   = pin_sync_r[0];
   assign ext_clk_in = pin_sync_r[1];
   assign bus_msg_in = pin_sync_r[2];

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral bus decode.

   // Answer is prepared in the setup cycle and given in the access cycle.
   assign setup     = psel && !penable;
   assign wr_access = psel && penable && pready && pwrite && !pslverr;

   // Only the five listed word offsets are mapped.
   always_comb begin
      case (paddr)
         `UFC_CONFIG_OFFSET,
         `UFC_IRQ_STAT_OFFSET,
         `UFC_IRQ_CLEAR_OFFSET,
         `UFC_IRQ_EN_OFFSET,
         `UFC_STATE_OFFSET: mapped = 1'b1;
         default:           mapped = 1'b0;
      endcase
   end

   // Read multiplexer; the clear register reads as zero.
   always_comb begin
      rd_word = 32'h0000_0000;
      case (paddr)
         `UFC_CONFIG_OFFSET:   rd_word[15:0] = cfg_r;
         `UFC_IRQ_STAT_OFFSET: rd_word[`UFC_IRQ_WIDTH-1:0] = irq_stat_r;
         `UFC_IRQ_EN_OFFSET:   rd_word[`UFC_IRQ_WIDTH-1:0] = irq_en_r;
         `UFC_STATE_OFFSET: begin
            rd_word[`UFC_ST_LATCH_OFF]  = latch_off;
            rd_word[`UFC_ST_TEMP_FAULT] = temp_fault;
            rd_word[`UFC_ST_MON_HIGH]   = mon_high;
            rd_word[`UFC_ST_CONFLICT]   = conflict;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Ready, error and read data stand for the single access cycle.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         if (setup && !pwrite) begin
            prdata <= rd_word;
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration register.

   // All sixteen bits are stored as written, reserved ones too.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= `UFC_CONFIG_RESET;
      end else if (wr_access && paddr == `UFC_CONFIG_OFFSET) begin
         cfg_r <= pwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt registers.

   // Enable register is plain read and write.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_r <= '0;
      end else if (wr_access && paddr == `UFC_IRQ_EN_OFFSET) begin
         irq_en_r <= pwdata[`UFC_IRQ_WIDTH-1:0];
      end
   end

   // Events: a new latch-off, a rising fault, a source conflict.
   always_comb begin
      irq_set = '0;
      irq_set[`UFC_IRQ_LATCH_OFF]  = !latch_off && mon_high && cfg_r.mon_en
                                     && cfg_r.temp_src == TEMP_SRC_MONITOR;
      irq_set[`UFC_IRQ_TEMP_FAULT] = sel_fault && !temp_fault_r;
      irq_set[`UFC_IRQ_CONFLICT]   = conflict;
   end

   assign irq_clr = (wr_access && paddr == `UFC_IRQ_CLEAR_OFFSET) ?
                    pwdata[`UFC_IRQ_WIDTH-1:0] : '0;

   // Sticky flags; a set in the clearing cycle wins over the clear.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      end
   end

   // Level interrupt while any enabled flag is set.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Minimum duty clamp and boot capacitor refresh.

   // Numerator is two times the setting plus two, denominator fixed.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         min_duty_enable    <= 1'b0;
         min_duty_numerator <= '0;
      end else begin
         min_duty_enable    <= cfg_r.min_duty_en;
         min_duty_numerator <= {1'b0, cfg_r.min_duty, 1'b0} + 7'h02;
      end
   end

   // Low-side pulse is forced each cycle only in diode emulation.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         force_low_side_pulse <= 1'b0;
      end else begin
         force_low_side_pulse <= cfg_r.boot_refresh && diode_emulation_mode
                                 && !low_side_min_elapsed;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared temperature pin and power good pin.

   // The shared pin serves either the sensor or tracking, never both.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         external_temp_sense_enable <= 1'b0;
         tracking_input             <= 1'b0;
         monitor_input_enable       <= 1'b0;
      end else begin
         external_temp_sense_enable <= cfg_r.ext_temp_sel;
         tracking_input             <= !cfg_r.ext_temp_sel;
         monitor_input_enable       <= cfg_r.mon_en;
      end
   end

   // Open drain releases the pin while power is good and pulls it low otherwise; push-pull always drives.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         power_good_output      <= 1'b0;
         power_good_output_oe_n <= 1'b0;
      end else if (cfg_r.pg_push_pull) begin
         power_good_output      <= power_good_status;
         power_good_output_oe_n <= 1'b0;
      end else begin
         power_good_output      <= 1'b0;
         power_good_output_oe_n <= power_good_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Temperature fault source and hard latch-off.

   // Picks the fault of the selected source; reserved code gives none.
   always_comb begin
      case (cfg_r.temp_src)
         TEMP_SRC_INTERNAL: sel_fault = temp_fault_in.internal;
         TEMP_SRC_EXTERNAL: sel_fault = temp_fault_in.external && cfg_r.ext_temp_sel;
         TEMP_SRC_MONITOR:  sel_fault = temp_fault_in.monitor && cfg_r.mon_en;
         default:           sel_fault = 1'b0;
      endcase
   end

   // The chosen source is not enabled, so software misconfigured it.
   assign conflict = (cfg_r.temp_src == TEMP_SRC_EXTERNAL && !cfg_r.ext_temp_sel)
                     || (cfg_r.temp_src == TEMP_SRC_MONITOR && !cfg_r.mon_en);

   // Registered fault level, also used for rising edge detection.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         temp_fault_r <= 1'b0;
         temp_fault   <= 1'b0;
      end else begin
         temp_fault_r <= sel_fault;
         temp_fault   <= sel_fault;
      end
   end

   // Latch-off ignores the fault threshold and holds until reset.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_off <= 1'b0;
      end else if (irq_set[`UFC_IRQ_LATCH_OFF]) begin
         latch_off <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Switching clock source and sync pin.

   // Selects the running clock and whether the sync pin is driven.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         use_external_clock <= 1'b0;
         switch_clock       <= 1'b0;
         sync_out           <= 1'b0;
         sync_oe_n          <= 1'b1;
      end else begin
         case (cfg_r.clk_src)
            CLK_SRC_INTERNAL: begin
               use_external_clock <= 1'b0;
               switch_clock       <= internal_clock;
               sync_out           <= 1'b0;
               sync_oe_n          <= 1'b1;
            end
            CLK_SRC_INT_OUT: begin
               use_external_clock <= 1'b0;
               switch_clock       <= internal_clock;
               sync_out           <= internal_clock;
               sync_oe_n          <= 1'b0;
            end
            CLK_SRC_EXTERNAL: begin
               use_external_clock <= 1'b1;
               switch_clock       <= ext_clk_in;
               sync_out           <= 1'b0;
               sync_oe_n          <= 1'b1;
            end
            default: begin
               use_external_clock <= 1'b0;
               switch_clock       <= internal_clock;
               sync_out           <= 1'b0;
               sync_oe_n          <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Inter-device fault bus.

   // Open-drain send and receive both gated by the bus enable.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_bus_out   <= 1'b0;
         fault_bus_oe_n  <= 1'b1;
         fault_bus_event <= 1'b0;
      end else begin
         fault_bus_out   <= 1'b0;
         fault_bus_oe_n  <= !(cfg_r.fault_bus_en && fault_send_req);
         fault_bus_event <= cfg_r.fault_bus_en && bus_msg_in;
      end
   end

endmodule

// ---- rtl/user_feature_config_map.svh ----
`ifndef USER_FEATURE_CONFIG_MAP_SVH
`define USER_FEATURE_CONFIG_MAP_SVH

// Byte offsets of the registers on the peripheral bus.
`define UFC_CONFIG_OFFSET    8'h00
`define UFC_IRQ_STAT_OFFSET  8'h04
`define UFC_IRQ_CLEAR_OFFSET 8'h08
`define UFC_IRQ_EN_OFFSET    8'h0C
`define UFC_STATE_OFFSET     8'h10

// Value of the configuration register after reset.
`define UFC_CONFIG_RESET     16'h0000

// Bit positions in the interrupt status, clear and enable registers.
`define UFC_IRQ_LATCH_OFF    0
`define UFC_IRQ_TEMP_FAULT   1
`define UFC_IRQ_CONFLICT     2
`define UFC_IRQ_WIDTH        3

// Bit positions in the read-only state register.
`define UFC_ST_LATCH_OFF     0
`define UFC_ST_TEMP_FAULT    1
`define UFC_ST_MON_HIGH      2
`define UFC_ST_CONFLICT      3

// Minimum duty clamp: fraction is numerator over this denominator.
`define UFC_DUTY_DENOM       10'h200
`define UFC_DUTY_NUM_WIDTH   7

`endif

// ---- rtl/user_feature_config_pkg.sv ----
package user_feature_config_pkg;

   // Source used to judge temperature faults.
   typedef enum logic [1:0] {
      TEMP_SRC_INTERNAL = 2'b00,
      TEMP_SRC_EXTERNAL = 2'b01,
      TEMP_SRC_MONITOR  = 2'b10,
      TEMP_SRC_UNUSED   = 2'b11
   } temp_src_type;

   // Source of the switching clock and use of the sync pin.
   typedef enum logic [1:0] {
      CLK_SRC_INTERNAL  = 2'b00,
      CLK_SRC_INT_OUT   = 2'b01,
      CLK_SRC_EXTERNAL  = 2'b10,
      CLK_SRC_UNUSED    = 2'b11
   } clk_src_type;

   // Field layout of the user feature configuration register.
   typedef struct packed {
      logic [4:0]   min_duty;
      logic         min_duty_en;
      logic         boot_refresh;
      logic         reserved8;
      logic         fault_bus_en;
      logic         ext_temp_sel;
      logic         pg_push_pull;
      temp_src_type temp_src;
      logic         mon_en;
      clk_src_type  clk_src;
   } ufc_type;

   // Temperature fault flags coming from the comparators.
   typedef struct packed {
      logic internal;
      logic external;
      logic monitor;
   } temp_fault_type;

endpackage

// ---- tb/user_feature_config_monitor.sv ----
`timescale 1ns/1ps
`include "user_feature_config_map.svh"
////////////////////////////////////////////////////////////////////////////////
// Checks the decoded outputs against a shadow copy of the configuration word.
module user_feature_config_monitor
   import user_feature_config_pkg::*;
(
   input wire logic                              clk,
   input wire logic                              rst_n,
   input wire logic                              psel,
   input wire logic                              penable,
   input wire logic                              pwrite,
   input wire logic [7:0]                        paddr,
   input wire logic [31:0]                       pwdata,
   input wire logic                              pready,
   input wire logic                              pslverr,
   input wire logic                              irq,
   input wire logic                              diode_emulation_mode,
   input wire logic                              low_side_min_elapsed,
   input wire logic                              power_good_status,
   input user_feature_config_pkg::temp_fault_type temp_fault_in,
   input wire logic                              internal_clock,
   input wire logic                              fault_send_req,
   input wire logic                              min_duty_enable,
   input wire logic [6:0]                        min_duty_numerator,
   input wire logic                              force_low_side_pulse,
   input wire logic                              external_temp_sense_enable,
   input wire logic                              tracking_input,
   input wire logic                              monitor_input_enable,
   input wire logic                              power_good_output,
   input wire logic                              power_good_output_oe_n,
   input wire logic                              temp_fault,
   input wire logic                              latch_off,
   input wire logic                              use_external_clock,
   input wire logic                              sync_out,
   input wire logic                              sync_oe_n,
   input wire logic                              fault_bus_out,
   input wire logic                              fault_bus_oe_n
);
   logic [15:0] cfg_r; // Shadow of the configuration word.
   logic [1:0]  up_r;  // Cycles since reset release, saturating at two.
   logic        pick;  // Fault flag of the selected temperature source.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   // Follows every accepted configuration write and counts out the reset.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= 16'h0000;
         up_r  <= 2'h0;
      end else begin
         if (psel && penable && pready && pwrite && paddr == `UFC_CONFIG_OFFSET) begin
            cfg_r <= pwdata[15:0];
         end
         if (up_r != 2'h2) begin
            up_r <= up_r + 2'h1;
         end
      end
   end
   // Chooses the fault of the source that the select field names.
   always_comb begin
      case (cfg_r[4:3])
         2'b00:   pick = temp_fault_in.internal;
         2'b01:   pick = temp_fault_in.external & cfg_r[6];
         2'b10:   pick = temp_fault_in.monitor & cfg_r[2];
         default: pick = 1'b0;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   duty_num_a: assert property (up_r[1] |->
      min_duty_numerator == {1'b0, $past(cfg_r[15:11]), 1'b0} + 7'h02)
      else $error("minimum duty numerator wrong");
   duty_en_a: assert property (up_r[1] |-> min_duty_enable == $past(cfg_r[10]))
      else $error("minimum duty enable wrong");
   boot_refresh_a: assert property (up_r[1] |->
      force_low_side_pulse == $past(cfg_r[9] & diode_emulation_mode & !low_side_min_elapsed))
      else $error("low side pulse wrong");
   pin_route_a: assert property (up_r[1] |->
      {tracking_input, external_temp_sense_enable} == {2{$past(cfg_r[6])}} ^ 2'b10)
      else $error("sensor or tracking routing wrong");
   good_style_a: assert property (up_r[1] |-> {power_good_output, power_good_output_oe_n} ==
      ($past(cfg_r[5]) ? {$past(power_good_status), 1'b0} : {1'b0, $past(power_good_status)}))
      else $error("power good drive wrong");
   fault_pick_a: assert property (up_r[1] |-> temp_fault == $past(pick))
      else $error("temperature fault source wrong");
   mon_enable_a: assert property (up_r[1] |-> monitor_input_enable == $past(cfg_r[2]))
      else $error("monitor enable wrong");
   latch_hold_a: assert property (latch_off |=> latch_off)
      else $error("latch off released");
   latch_cause_a: assert property ($rose(latch_off) |-> $past(cfg_r[4:2]) == 3'b101)
      else $error("latch off without monitor source");
   clock_pick_a: assert property (up_r[1] |-> use_external_clock == ($past(cfg_r[1:0]) == 2'b10))
      else $error("clock source wrong");
   sync_drive_a: assert property (up_r[1] |-> sync_oe_n == ($past(cfg_r[1:0]) != 2'b01)
      && sync_out == ($past(cfg_r[1:0]) == 2'b01 && $past(internal_clock)))
      else $error("sync pin drive wrong");
   fault_bus_a: assert property (up_r[1] |->
      !fault_bus_out && fault_bus_oe_n == !$past(cfg_r[7] & fault_send_req))
      else $error("fault bus drive wrong");
   ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("bus answer timing wrong");
   cover property ($rose(latch_off));
   cover property (pslverr);
   cover property ($rose(irq));
   cover property (temp_fault && $past(cfg_r[4:3]) == 2'b01);
endmodule
bind user_feature_config user_feature_config_monitor mon (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .irq, .diode_emulation_mode, .low_side_min_elapsed, .power_good_status,
   .temp_fault_in, .internal_clock, .fault_send_req, .min_duty_enable, .min_duty_numerator, .force_low_side_pulse,
   .external_temp_sense_enable, .tracking_input, .monitor_input_enable, .power_good_output, .power_good_output_oe_n,
   .temp_fault, .latch_off, .use_external_clock, .sync_out, .sync_oe_n, .fault_bus_out, .fault_bus_oe_n);

// ---- tb/user_feature_config_bench.sv ----
`timescale 1ns/1ps
`include "user_feature_config_map.svh"
////////////////////////////////////////////////////////////////////////////////
// Drives the bus and pins of the block and compares its outputs.
module user_feature_config_bench;
   import user_feature_config_pkg::*;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        diode_emulation_mode, low_side_min_elapsed, power_good_status, monitor_above_limit;
   logic        internal_clock, sync_in, fault_bus_in, fault_send_req, min_duty_enable, force_low_side_pulse;
   logic        external_temp_sense_enable, tracking_input, monitor_input_enable, power_good_output;
   logic        power_good_output_oe_n, temp_fault, latch_off, use_external_clock, switch_clock, sync_out;
   logic        sync_oe_n, fault_bus_out, fault_bus_oe_n, fault_bus_event;
   logic [6:0]  min_duty_numerator;
   logic [15:0] v;
   logic [15:0] vals [4] = '{16'hFFFF, 16'h0000, 16'h5AA5, 16'hA55A}; // Covers all clock codes.
   temp_fault_type temp_fault_in;
   int          bad_count = 0;
   int          checks = 0;
   user_feature_config dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .irq, .diode_emulation_mode, .low_side_min_elapsed, .power_good_status, .temp_fault_in, .monitor_above_limit,
      .internal_clock, .sync_in, .fault_bus_in, .fault_send_req, .min_duty_enable, .min_duty_numerator,
      .force_low_side_pulse, .external_temp_sense_enable, .tracking_input, .monitor_input_enable, .power_good_output,
      .power_good_output_oe_n, .temp_fault, .latch_off, .use_external_clock, .switch_clock, .sync_out, .sync_oe_n,
      .fault_bus_out, .fault_bus_oe_n, .fault_bus_event);
   ////////////////////////////////////////////////////////////////////////////
   // Counts a comparison and reports a mismatch at once.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic give_verdict();
      if (bad_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // One bus transfer; the request stays up when another follows at once.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic hold);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      if (!hold) begin
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge clk);
      end
   endtask
   // Writes one word and releases the bus.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask
   // Reads one word and compares data and error flag.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
      apb(1'b0, a, 32'h0000_0000, 1'b0);
      check(q, exp);
      check(e, err);
   endtask
   // Lets a number of clock edges pass.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Free running core clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Cuts a hang short.
   initial begin
      tick(5000);
      bad_count++;
      give_verdict();
   end
   // Main sequence of tests.
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, diode_emulation_mode, low_side_min_elapsed} = '0;
      {power_good_status, monitor_above_limit, sync_in, fault_bus_in, fault_send_req} = '0;
      internal_clock = 1'b1;
      temp_fault_in = 3'b000;
      tick(16);
      rst_n <= 1'b1;
      tick(3);
      check({tracking_input, sync_oe_n, fault_bus_oe_n, latch_off}, 4'hE);
      rd(`UFC_CONFIG_OFFSET, 32'h0000_0000, 1'b0);
      apb(1'b1, `UFC_CONFIG_OFFSET, 32'h0000_0100, 1'b1);
      rd(`UFC_CONFIG_OFFSET, 32'h0000_0100, 1'b0);
      for (int i = 0; i < 4; i++) begin
         v = vals[i];
         diode_emulation_mode <= 1'b1;
         low_side_min_elapsed <= i[1];
         power_good_status    <= i[0];
         fault_send_req       <= 1'b1;
         fault_bus_in         <= 1'b1;
         wr(`UFC_CONFIG_OFFSET, {16'h1234, v});
         tick(4);
         rd(`UFC_CONFIG_OFFSET, {16'h0000, v}, 1'b0);
         check(min_duty_numerator, {v[15:11], 1'b0} + 7'h02);
         check(min_duty_enable, v[10]);
         check(force_low_side_pulse, v[9] & !i[1]);
         check({tracking_input, external_temp_sense_enable}, {!v[6], v[6]});
         check({power_good_output, power_good_output_oe_n}, {v[5] & i[0], !v[5] & i[0]});
         check(monitor_input_enable, v[2]);
         check({use_external_clock, switch_clock}, {v[1:0] == 2'b10, v[1:0] != 2'b10});
         check({sync_oe_n, sync_out}, {v[1:0] != 2'b01, v[1:0] == 2'b01});
         check({fault_bus_oe_n, fault_bus_event, fault_bus_out}, {!v[7], v[7], 1'b0});
      end
      for (int s = 0; s < 4; s++) begin
         temp_fault_in <= (s == 3) ? 3'b111 : 3'b100 >> s;
         wr(`UFC_CONFIG_OFFSET, 32'h0044 | (s << 3));
         tick(4);
         check(temp_fault, s != 3);
      end
      wr(`UFC_CONFIG_OFFSET, 32'h0000_0008);
      tick(4);
      check(temp_fault, 1'b0);
      rd(`UFC_STATE_OFFSET, 32'h0000_0008, 1'b0);
      temp_fault_in <= 3'b000;
      wr(`UFC_CONFIG_OFFSET, 32'h0000_0000);
      tick(3);
      wr(`UFC_IRQ_CLEAR_OFFSET, 32'h0000_0007);
      rd(`UFC_IRQ_STAT_OFFSET, 32'h0000_0000, 1'b0);
      wr(`UFC_IRQ_EN_OFFSET, 32'h0000_0002);
      temp_fault_in <= 3'b100;
      tick(4);
      check(irq, 1'b1);
      rd(`UFC_IRQ_STAT_OFFSET, 32'h0000_0002, 1'b0);
      wr(`UFC_IRQ_EN_OFFSET, 32'h0000_0000);
      tick(2);
      check(irq, 1'b0);
      wr(`UFC_IRQ_STAT_OFFSET, 32'h0000_0007);
      rd(`UFC_IRQ_STAT_OFFSET, 32'h0000_0002, 1'b0);
      wr(`UFC_IRQ_CLEAR_OFFSET, 32'h0000_0002);
      rd(`UFC_IRQ_STAT_OFFSET, 32'h0000_0000, 1'b0);
      rd(`UFC_IRQ_CLEAR_OFFSET, 32'h0000_0000, 1'b0);
      rd(8'h14, 32'h0000_0000, 1'b1);
      temp_fault_in <= 3'b000;
      monitor_above_limit <= 1'b1;
      wr(`UFC_CONFIG_OFFSET, 32'h0000_0010);
      tick(6);
      check(latch_off, 1'b0);
      wr(`UFC_IRQ_CLEAR_OFFSET, 32'h0000_0007);
      wr(`UFC_IRQ_EN_OFFSET, 32'h0000_0001);
      wr(`UFC_CONFIG_OFFSET, 32'h0000_0014);
      tick(6);
      check({latch_off, irq}, 2'b11);
      rd(`UFC_STATE_OFFSET, 32'h0000_0005, 1'b0);
      monitor_above_limit <= 1'b0;
      wr(`UFC_CONFIG_OFFSET, 32'h0000_0000);
      tick(6);
      check(latch_off, 1'b1);
      rst_n <= 1'b0;
      tick(2);
      check({latch_off, irq}, 2'b00);
      rst_n <= 1'b1;
      tick(3);
      rd(`UFC_CONFIG_OFFSET, 32'h0000_0000, 1'b0);
      give_verdict();
   end
endmodule
